// File: bscat_top.sv
/*
 * Band-select and control-link logic of the amplifier: band source choice,
 * power level, long-transmission drop, transmit inhibit and cyclic polling.
 * Assumes all pins but rst_b and band_data_in are synchronous to sys_clk; analog thresholds (remote
 * power-on window, RF counter) are resolved outside to logic levels.
 */
// The register addresses and the plain strobed port were decided locally.
// Functional notes
// - band code 0x0..0xA maps to 60,160,80,40,30,20,17,15,12,10,6 m
// - full power, digital mode, one transmission over 8 s drops to half power
// - high-active inhibit rests low, driven high to stop transmitting
// - low-active inhibit is open collector, pulls low to stop transmitting
// - remote power-on voltage present switches the device on
// - address disabled: only listen on the shared link, never query
// - address set: poll the transceiver cyclically for its frequency; the code polls only with the CAT band source selected
// - other controllers querying cause collisions; disable polling then
// - both ends use the same baud rate on the link
// - power key steps full, half, reduced, full
// - with no link configured, band comes from the internal counter only
`default_nettype none
`include "bscat_defs.svh"
module bscat_top
    import bscat_pkg::*;
#(
    parameter int unsigned LONG_TX_CYC = `BSCAT_LONG_TX_S * `BSCAT_CLK_HZ,
    parameter int unsigned SETTLE_CYC = (`BSCAT_CLK_HZ / 1000000) * `BSCAT_SETTLE_US,
    parameter int unsigned POLL_CYC = (`BSCAT_CLK_HZ / 1000) * `BSCAT_POLL_MS
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [3:0] band_data_in,
    input wire logic [3:0] cnt_band_in,
    input wire logic ptt_in,
    input wire logic power_key,
    input wire logic remote_on_in,
    input wire logic vendor_ttl_strap,
    input wire logic cat_rxd,
    output logic cat_txd,
    output logic [3:0] band_sel,
    output logic [1:0] power_level,
    output logic power_on,
    output logic ttl_sel,
    output logic inhibit_out_high_active,
    output logic inhibit_out_low_active,
    output logic inhibit_out_low_active_oe,
    input wire logic inhibit_out_low_active_in
);
    logic rst_s1_q;
    logic rst_n;
    bscat_ser_if sif ();
    bscat_band_t dec_band;

    logic [2:0] ctrl_q;
    logic [7:0] cat_addr_q;
    logic [15:0] baud_q;
    logic [3:0] cat_band_q;
    logic [31:0] freq_q;
    bscat_src_t src;
    logic digital;

    bscat_band_t band_q;
    logic [3:0] new_band;
    logic new_ok;
    logic chg;
    logic [19:0] settle_q;
    logic inhib_q;

    bscat_pwr_t pwr_q;
    logic key_prev_q;
    logic press;
    logic [29:0] lt_cnt_q;
    logic lt_run;
    logic drop;

    bscat_poll_t poll_q;
    logic [23:0] poll_tmr_q;
    logic [1:0] qidx_q;
    logic poll_on;

    // reset enters asynchronously, is released on the clock
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    bscat_band_dec #(.W(4)) u_dec (
        .clk(sys_clk),
        .rst_n(rst_n),
        .bits_in(band_data_in),
        .band(dec_band)
    );

    bscat_uart u_uart (
        .clk(sys_clk),
        .rst_n(rst_n),
        .sif(sif),
        .rxd(cat_rxd),
        .txd(cat_txd)
    );

    assign src = (ctrl_q[1:0] == 2'h3) ? SRC_NONE : bscat_src_t'(ctrl_q[1:0]);
    assign digital = ctrl_q[`BSCAT_CTRL_DIG];
    assign sif.baud_div = baud_q;

    // register writes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `BSCAT_CTRL_RST;
            cat_addr_q <= `BSCAT_CAT_OFF;
            baud_q <= `BSCAT_BAUD_RST;
            cat_band_q <= 4'h0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `BSCAT_A_CTRL: ctrl_q <= reg_wdata[2:0];
                `BSCAT_A_CATADDR: cat_addr_q <= reg_wdata[7:0];
                `BSCAT_A_BAUD: baud_q <= (reg_wdata[15:0] < 16'h0002) ? 16'h0002 : reg_wdata[15:0];
                `BSCAT_A_CATBAND: begin
                    if (bscat_band_ok(reg_wdata[3:0])) begin
                        cat_band_q <= reg_wdata[3:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // read data stands for exactly the cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            unique case (reg_addr)
                `BSCAT_A_CTRL: reg_rdata <= {29'h0, ctrl_q};
                `BSCAT_A_CATADDR: reg_rdata <= {24'h0, cat_addr_q};
                `BSCAT_A_BAUD: reg_rdata <= {16'h0, baud_q};
                `BSCAT_A_CATBAND: reg_rdata <= {28'h0, cat_band_q};
                `BSCAT_A_STATUS: reg_rdata <= {20'h0, poll_q, inhibit_out_low_active_in,
                    ttl_sel, power_on, inhib_q, pwr_q, band_q};
                `BSCAT_A_FREQ: reg_rdata <= freq_q;
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // frequency bytes heard on the link, polled or unsolicited
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            freq_q <= 32'h0000_0000;
        end else if (sif.rx_valid) begin
            freq_q <= {freq_q[23:0], sif.rx_data};
        end
    end

    // band source selection
    always_comb begin
        unique case (src)
            SRC_BDATA: new_band = dec_band;
            SRC_CAT: new_band = cat_band_q;
            default: new_band = cnt_band_in;
        endcase
        new_ok = bscat_band_ok(new_band);
    end
    assign chg = new_ok && (new_band != band_q);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            band_q <= BAND_60M;
            settle_q <= 20'h00000;
        end else if (chg) begin
            band_q <= bscat_band_t'(new_band);
            settle_q <= 20'(SETTLE_CYC);
        end else if (settle_q != 20'h00000) begin
            settle_q <= settle_q - 20'h00001;
        end
    end

    // inhibit rises in the same edge the relay code moves
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            inhib_q <= 1'b0;
            band_sel <= 4'h0;
            inhibit_out_high_active <= 1'b0;
            inhibit_out_low_active <= 1'b0;
            inhibit_out_low_active_oe <= 1'b0;
        end else begin
            inhib_q <= chg || (settle_q > 20'h00001);
            band_sel <= chg ? new_band : band_q;
            inhibit_out_high_active <= chg || (settle_q > 20'h00001);
            inhibit_out_low_active <= 1'b0;
            inhibit_out_low_active_oe <= chg || (settle_q > 20'h00001);
        end
    end

    // strap and remote power-on
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ttl_sel <= 1'b0;
            power_on <= 1'b0;
        end else begin
            ttl_sel <= !vendor_ttl_strap;
            power_on <= remote_on_in;
        end
    end

    // power level; the long-transmission drop outranks a key press
    assign press = power_key && !key_prev_q;
    assign lt_run = ptt_in && digital && (pwr_q == PWR_FULL);
    assign drop = lt_run && (lt_cnt_q == 30'(LONG_TX_CYC));

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lt_cnt_q <= 30'h0;
        end else if (!lt_run || drop) begin
            lt_cnt_q <= 30'h0;
        end else begin
            lt_cnt_q <= lt_cnt_q + 30'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_prev_q <= 1'b0;
            pwr_q <= PWR_FULL;
            power_level <= PWR_FULL;
        end else begin
            key_prev_q <= power_key;
            if (drop) begin
                pwr_q <= PWR_HALF;
                power_level <= PWR_HALF;
            end else if (press) begin
                pwr_q <= bscat_pwr_step(pwr_q);
                power_level <= bscat_pwr_step(pwr_q);
            end
        end
    end

    // cyclic query, held back while the line is busy to avoid a collision
    assign poll_on = (src == SRC_CAT) && (cat_addr_q != `BSCAT_CAT_OFF);

    function automatic logic [7:0] query_byte(input logic [1:0] i, input logic [7:0] a);
        unique case (i)
            2'h0: return `BSCAT_Q_SOF;
            2'h1: return a;
            2'h2: return `BSCAT_Q_CMD;
            default: return `BSCAT_Q_EOF;
        endcase
    endfunction : query_byte

    assign sif.tx_valid = (poll_q == P_SEND) && poll_on;
    assign sif.tx_data = query_byte(qidx_q, cat_addr_q);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            poll_q <= P_IDLE;
            poll_tmr_q <= 24'h0;
            qidx_q <= 2'h0;
        end else begin
            unique case (poll_q)
                P_IDLE: begin
                    if (poll_on) begin
                        poll_q <= P_WAIT;
                        poll_tmr_q <= 24'(POLL_CYC - 1);
                    end
                end
                P_WAIT: begin
                    if (!poll_on) begin
                        poll_q <= P_IDLE;
                    end else if (poll_tmr_q != 24'h0) begin
                        poll_tmr_q <= poll_tmr_q - 24'h1;
                    end else if (!sif.rx_busy) begin
                        poll_q <= P_SEND;
                        qidx_q <= 2'h0;
                    end
                end
                P_SEND: begin
                    if (!poll_on) begin
                        poll_q <= P_IDLE;
                    end else if (sif.tx_ready) begin
                        qidx_q <= qidx_q + 2'h1;
                        if (qidx_q == `BSCAT_Q_LAST) begin
                            poll_q <= P_WAIT;
                            poll_tmr_q <= 24'(POLL_CYC - 1);
                        end
                    end
                end
                default: poll_q <= P_IDLE;
            endcase
        end
    end

    a_band_change_inhibit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(band_q) |-> inhib_q && inhibit_out_high_active)
        else $error("band moved without inhibit");
    a_inhibit_held_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(band_q) |-> inhib_q [*4]) else $error("inhibit dropped during settle");
    a_inhibit_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
        inhibit_out_high_active == inhibit_out_low_active_oe && !inhibit_out_low_active)
        else $error("inhibit outputs disagree");
    a_no_query_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cat_addr_q == `BSCAT_CAT_OFF |-> !sif.tx_valid) else $error("query sent while disabled");
    a_poll_starts: assert property (@(posedge sys_clk) disable iff (!rst_n)
        poll_q == P_WAIT && poll_on && poll_tmr_q == 24'h0 && !sif.rx_busy
        |=> poll_q == P_SEND) else $error("due poll not started");
    a_long_tx_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        drop |=> pwr_q == PWR_HALF && power_level == PWR_HALF) else $error("no drop to half");
    a_key_steps: assert property (@(posedge sys_clk) disable iff (!rst_n)
        press && !drop |=> pwr_q == bscat_pwr_step($past(pwr_q))) else $error("bad power step");
    a_remote_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
        remote_on_in |=> power_on) else $error("remote power-on ignored");
    a_counter_band: assert property (@(posedge sys_clk) disable iff (!rst_n)
        src == SRC_NONE && bscat_band_ok(cnt_band_in) |=> band_q == $past(cnt_band_in))
        else $error("counter band not followed");
endmodule : bscat_top
`default_nettype wire

// File: bscat_defs.svh
/*
 * Constants for the band-select and CAT control block: register indexes, field
 * positions, reset values and timing figures.
 * Assumes a 125 MHz system clock; included by bare name.
 */
`ifndef BSCAT_DEFS_SVH
`define BSCAT_DEFS_SVH

`define BSCAT_CLK_HZ 125000000
`define BSCAT_LONG_TX_S 8
`define BSCAT_SETTLE_US 6000
`define BSCAT_POLL_MS 100

`define BSCAT_A_CTRL 4'h0
`define BSCAT_A_CATADDR 4'h1
`define BSCAT_A_BAUD 4'h2
`define BSCAT_A_CATBAND 4'h3
`define BSCAT_A_STATUS 4'h4
`define BSCAT_A_FREQ 4'h5

`define BSCAT_CTRL_SRC_LO 0
`define BSCAT_CTRL_DIG 2
`define BSCAT_CTRL_RST 3'h1
`define BSCAT_BAUD_RST 16'h32DD
`define BSCAT_CAT_OFF 8'h00

`define BSCAT_BAND_MAX 4'hA
`define BSCAT_Q_SOF 8'hFE
`define BSCAT_Q_CMD 8'h03
`define BSCAT_Q_EOF 8'hFD
`define BSCAT_Q_LAST 2'h3

`endif

// File: bscat_pkg.sv
/*
 * Types and shared decode functions of the band-select and CAT control block.
 * Assumes nothing beyond the constants header.
 */
`default_nettype none
`include "bscat_defs.svh"
package bscat_pkg;
    typedef enum logic [3:0] {
        BAND_60M = 4'h0, BAND_160M = 4'h1, BAND_80M = 4'h2, BAND_40M = 4'h3,
        BAND_30M = 4'h4, BAND_20M = 4'h5, BAND_17M = 4'h6, BAND_15M = 4'h7,
        BAND_12M = 4'h8, BAND_10M = 4'h9, BAND_6M = 4'hA
    } bscat_band_t;
    typedef enum logic [1:0] {PWR_FULL = 2'h0, PWR_HALF = 2'h1, PWR_LOW = 2'h3} bscat_pwr_t;
    typedef enum logic [1:0] {SRC_NONE = 2'h0, SRC_BDATA = 2'h1, SRC_CAT = 2'h2} bscat_src_t;
    typedef enum logic [1:0] {P_IDLE = 2'h0, P_WAIT = 2'h1, P_SEND = 2'h3} bscat_poll_t;

    function automatic logic bscat_band_ok(input logic [3:0] code);
        return code <= `BSCAT_BAND_MAX;
    endfunction : bscat_band_ok

    function automatic bscat_pwr_t bscat_pwr_step(input bscat_pwr_t p);
        unique case (p)
            PWR_FULL: return PWR_HALF;
            PWR_HALF: return PWR_LOW;
            default: return PWR_FULL;
        endcase
    endfunction : bscat_pwr_step
endpackage : bscat_pkg
`default_nettype wire

// File: bscat_ser_if.sv
/*
 * Byte-level carrier between the control logic and the serial engine.
 * Assumes both ends run on the same clock.
 */
`default_nettype none
interface bscat_ser_if;
    logic tx_valid;
    logic tx_ready;
    logic [7:0] tx_data;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_busy;
    logic [15:0] baud_div;
    modport ctl (output tx_valid, tx_data, baud_div, input tx_ready, rx_valid, rx_data, rx_busy);
    modport uart (input tx_valid, tx_data, baud_div, output tx_ready, rx_valid, rx_data, rx_busy);
endinterface : bscat_ser_if
`default_nettype wire

// File: bscat_uart.sv
/*
 * Serial engine for the shared control link: 8N1, one divisor for both
 * directions. Assumes rxd is already synchronous and idles high.
 */
`default_nettype none
module bscat_uart
    import bscat_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    bscat_ser_if.uart sif,
    input wire logic rxd,
    output logic txd
);
    logic tx_busy_q;
    logic [9:0] tx_sh_q;
    logic [3:0] tx_bits_q;
    logic [15:0] tx_cnt_q;
    logic rx_act_q;
    logic [3:0] rx_bits_q;
    logic [15:0] rx_cnt_q;
    logic [7:0] rx_sh_q;
    logic rx_valid_q;

    assign sif.tx_ready = !tx_busy_q;
    assign sif.rx_valid = rx_valid_q;
    assign sif.rx_data = rx_sh_q;
    assign sif.rx_busy = rx_act_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_busy_q <= 1'b0;
            tx_sh_q <= 10'h3FF;
            tx_bits_q <= 4'h0;
            tx_cnt_q <= 16'h0000;
            txd <= 1'b1;
        end else if (!tx_busy_q) begin
            if (sif.tx_valid) begin
                tx_busy_q <= 1'b1;
                tx_sh_q <= {1'b1, sif.tx_data, 1'b0};
                tx_bits_q <= 4'hA;
                tx_cnt_q <= 16'h0000;
            end
        end else if (tx_cnt_q != 16'h0000) begin
            tx_cnt_q <= tx_cnt_q - 16'h0001;
        end else if (tx_bits_q != 4'h0) begin
            txd <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            tx_bits_q <= tx_bits_q - 4'h1;
            tx_cnt_q <= sif.baud_div - 16'h0001;
        end else begin
            tx_busy_q <= 1'b0;
        end
    end

    // a line that stays low through the stop bit is a broken frame: no byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_act_q <= 1'b0;
            rx_bits_q <= 4'h0;
            rx_cnt_q <= 16'h0000;
            rx_sh_q <= 8'h00;
            rx_valid_q <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            if (!rx_act_q) begin
                if (!rxd) begin
                    rx_act_q <= 1'b1;
                    rx_bits_q <= 4'h0;
                    // the start edge is seen a cycle late, so aim one cycle earlier to sample
                    // mid-bit; the divisor is never below 2, so this cannot wrap
                    rx_cnt_q <= {1'b0, sif.baud_div[15:1]} - 16'h0001;
                end
            end else if (rx_cnt_q != 16'h0000) begin
                rx_cnt_q <= rx_cnt_q - 16'h0001;
            end else begin
                rx_cnt_q <= sif.baud_div - 16'h0001;
                rx_bits_q <= rx_bits_q + 4'h1;
                if (rx_bits_q == 4'h0 && rxd) begin
                    rx_act_q <= 1'b0;
                end else if (rx_bits_q == 4'h9) begin
                    rx_act_q <= 1'b0;
                    rx_valid_q <= rxd;
                end else if (rx_bits_q != 4'h0) begin
                    rx_sh_q <= {rxd, rx_sh_q[7:1]};
                end
            end
        end
    end

    a_tx_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
        !tx_busy_q |-> txd) else $error("serial line not idle high between bytes");
endmodule : bscat_uart
`default_nettype wire

// File: bscat_band_dec.sv
/*
 * Band-data decoder: synchronises the four band bits and keeps the last
 * legal band code. Assumes the bits come from the transceiver as levels.
 */
`default_nettype none
module bscat_band_dec
    import bscat_pkg::*;
#(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] bits_in,
    output bscat_band_t band
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= bits_in;
            s2_q <= s1_q;
        end
    end

    // codes above the table keep the old band rather than move relays
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            band <= BAND_60M;
        end else if (bscat_band_ok(s2_q)) begin
            band <= bscat_band_t'(s2_q);
        end
    end

    a_legal_code_taken: assert property (@(posedge clk) disable iff (!rst_n)
        bscat_band_ok(s2_q) |=> band == $past(s2_q)) else $error("legal band code not taken");
    a_illegal_code_kept: assert property (@(posedge clk) disable iff (!rst_n)
        !bscat_band_ok(s2_q) |=> $stable(band)) else $error("illegal band code moved band");
endmodule : bscat_band_dec
`default_nettype wire

// File: bscat_xcvr_model.sv
/*
 * Transceiver stand-in on the far side: band bits A..D and the shared 8N1 link.
 * Assumes the amplifier uses BIT_CYC clocks per bit and the link idles high.
 */
`default_nettype none
module bscat_xcvr_model #(
    parameter int BIT_CYC = 4
) (
    input wire logic clk,
    input wire logic amp_txd,
    output logic xcvr_txd,
    output logic [3:0] band_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$];
    initial begin
        xcvr_txd = 1'b1;
        band_bits = 4'h0;
    end
    // one bit time both ways: a mismatch only shows up as garbled bytes
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            xcvr_txd <= fr[i];
            repeat (BIT_CYC) @(posedge clk);
        end
    endtask : send_byte
    task automatic set_band(input logic [3:0] c);
        band_bits <= c;
    endtask : set_band
    initial begin : rx_loop
        logic [7:0] b;
        forever begin
            @(negedge amp_txd);
            repeat (BIT_CYC / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge clk);
                b[i] = amp_txd;
            end
            repeat (BIT_CYC) @(posedge clk);
            rx_q.push_back(b);
        end
    end
endmodule : bscat_xcvr_model
`default_nettype wire

// File: tb.sv
/*
 * Self-checking bench for the band-select and link block.
 * Assumes short counts: long tx 50, settle 20, poll 100 cycles; baud set to 4.
 */
`default_nettype none
`include "bscat_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LONG_CYC = 50;
    localparam int SETTLE = 20;
    localparam int POLL = 100;
    logic sys_clk;
    logic rst_b;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [3:0] band_bits;
    logic [3:0] cnt_band;
    logic ptt;
    logic pkey;
    logic remote_on;
    logic strap;
    logic cat_txd;
    logic cat_rxd;
    logic [3:0] band_sel;
    logic [1:0] power_level;
    logic power_on;
    logic ttl_sel;
    logic inh_hi;
    logic inh_lo;
    logic inh_lo_oe;
    wire inh_lo_line;
    logic [31:0] d;
    int n_mismatch = 0;
    int tests_run = 0;
    // pull-up sits at the transceiver end of the open-collector line
    assign inh_lo_line = inh_lo_oe ? inh_lo : 1'b1;
    bscat_top #(.LONG_TX_CYC(LONG_CYC), .SETTLE_CYC(SETTLE), .POLL_CYC(POLL)) i_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .band_data_in(band_bits),
        .cnt_band_in(cnt_band), .ptt_in(ptt), .power_key(pkey), .remote_on_in(remote_on),
        .vendor_ttl_strap(strap), .cat_rxd(cat_rxd), .cat_txd(cat_txd), .band_sel(band_sel),
        .power_level(power_level), .power_on(power_on), .ttl_sel(ttl_sel),
        .inhibit_out_high_active(inh_hi), .inhibit_out_low_active(inh_lo),
        .inhibit_out_low_active_oe(inh_lo_oe), .inhibit_out_low_active_in(inh_lo_line));
    bscat_xcvr_model #(.BIT_CYC(4)) i_xcvr (
        .clk(sys_clk), .amp_txd(cat_txd), .xcvr_txd(cat_rxd), .band_bits(band_bits));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic band_to(input logic [3:0] c, input logic via_cnt);
        int k;
        k = 0;
        @(posedge sys_clk);
        if (via_cnt) cnt_band <= c;
        else i_xcvr.set_band(c);
        do begin
            @(posedge sys_clk);
            #1 k++;
        end while (band_sel !== c && k < 20);
        chk("band_sel", {28'h0, band_sel}, {28'h0, c});
        chk("inhibit high", {31'h0, inh_hi}, 32'h1);
        chk("inhibit line", {31'h0, inh_lo_line}, 32'h0);
        repeat (SETTLE - 3) @(posedge sys_clk);
        #1 chk("inhibit held", {30'h0, inh_hi, inh_lo_line}, 32'h2);
        repeat (7) @(posedge sys_clk);
        #1 chk("inhibit released", {30'h0, inh_hi, inh_lo_line}, 32'h1);
    endtask : band_to
    task automatic t_reset();
        #1 chk("idle outputs", {29'h0, cat_txd, inh_hi, inh_lo_oe}, 32'h4);
        rd(`BSCAT_A_CTRL, d);
        chk("ctrl reset", d, 32'h1);
        rd(`BSCAT_A_BAUD, d);
        chk("baud reset", d, 32'h32DD);
        wr(4'hF, 32'hFFFF_FFFF);
        rd(4'hF, d);
        chk("unmapped", d, 32'h0);
    endtask : t_reset
    task automatic t_straps();
        @(posedge sys_clk);
        remote_on <= 1'b1;
        strap <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 chk("power on, ttl", {30'h0, power_on, ttl_sel}, 32'h3);
        @(posedge sys_clk);
        remote_on <= 1'b0;
        strap <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chk("power off, rs232", {30'h0, power_on, ttl_sel}, 32'h0);
    endtask : t_straps
    task automatic t_bands();
        for (int c = 1; c <= 10; c++) band_to(c[3:0], 1'b0);
        band_to(4'h0, 1'b0);
        for (int c = 11; c <= 15; c++) begin
            @(posedge sys_clk);
            i_xcvr.set_band(c[3:0]);
            repeat (6) @(posedge sys_clk);
            #1 chk("bad code", {27'h0, inh_hi, band_sel}, 32'h0);
        end
    endtask : t_bands
    task automatic t_power();
        logic [1:0] exp[3] = '{2'h1, 2'h3, 2'h0};
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            pkey <= 1'b1;
            repeat (2) @(posedge sys_clk);
            pkey <= 1'b0;
            repeat (2) @(posedge sys_clk);
            #1 chk("power step", {30'h0, power_level}, {30'h0, exp[i]});
        end
    endtask : t_power
    task automatic t_long();
        wr(`BSCAT_A_CTRL, 32'h5);
        @(posedge sys_clk);
        ptt <= 1'b1;
        repeat (LONG_CYC - 5) @(posedge sys_clk);
        #1 chk("still full", {30'h0, power_level}, 32'h0);
        repeat (10) @(posedge sys_clk);
        #1 chk("long tx drop", {30'h0, power_level}, 32'h1);
        @(posedge sys_clk);
        ptt <= 1'b0;
    endtask : t_long
    task automatic t_link();
        int k;
        wr(`BSCAT_A_CTRL, 32'h0);
        band_to(4'h7, 1'b1);
        wr(`BSCAT_A_BAUD, 32'h4);
        wr(`BSCAT_A_CTRL, 32'h2);
        @(posedge sys_clk);
        for (int i = 1; i <= 4; i++) i_xcvr.send_byte(8'h11 * i[7:0]);
        repeat (POLL * 3) @(posedge sys_clk);
        chk("queries sent", i_xcvr.rx_q.size(), 32'h0);
        rd(`BSCAT_A_FREQ, d);
        chk("freq bytes", d, 32'h1122_3344);
        wr(`BSCAT_A_CATBAND, 32'h9);
        wr(`BSCAT_A_CATBAND, 32'hC);
        rd(`BSCAT_A_CATBAND, d);
        chk("catband kept", d, 32'h9);
        wr(`BSCAT_A_CATADDR, 32'h5A);
        k = 0;
        while (i_xcvr.rx_q.size() < 4 && k < POLL * 4) begin
            @(posedge sys_clk);
            k++;
        end
        chk("query", i_xcvr.rx_q.size() >= 4 ? {i_xcvr.rx_q[0], i_xcvr.rx_q[1],
            i_xcvr.rx_q[2], i_xcvr.rx_q[3]} : 32'h0, 32'hFE5A_03FD);
    endtask : t_link
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end
    initial begin
        {rst_b, reg_addr, reg_wdata, reg_wr, reg_rd, cnt_band, ptt, pkey, remote_on} = '0;
        strap = 1'b1;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge sys_clk);
        t_reset();
        t_straps();
        t_bands();
        t_power();
        t_long();
        t_link();
        summarize();
    end
endmodule : tb
`default_nettype wire
